// ---- inc/srs_consts.svh ----
// Constants for the speed reference selector: register map, resets, timing.
// Assumes one 250 MHz control clock.
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SRS_REG_SOURCE      5'h00
`define SRS_REG_PRESET_SEL  5'h01
`define SRS_REG_AUTO_DIS    5'h02
`define SRS_REG_RAMP_MODE   5'h03
`define SRS_REG_DWELL       5'h04
`define SRS_REG_KEYPAD      5'h05
`define SRS_REG_PREC_COARSE 5'h06
`define SRS_REG_PREC_FINE   5'h07
`define SRS_REG_STATUS      5'h08
`define SRS_REG_TERM_DEST   5'h09
`define SRS_REG_PRESET0     5'h10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRS_RST_SOURCE      3'h0
`define SRS_RST_PRESET_SEL  4'h0
`define SRS_RST_AUTO_DIS    1'h0
`define SRS_RST_RAMP_MODE   2'h1
`define SRS_PRESET_SCAN     4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRS_CLK_MHZ         250
`define SRS_STALL_SECONDS   10
// Worked out in 64 bits: ten seconds of cycles overflows a 32-bit int
`define SRS_STALL_CYCLES    (`SRS_STALL_SECONDS * `SRS_CLK_MHZ * 64'd1000000)

`endif

// ---- inc/srs_pkg.sv ----
// Types for the speed reference selector.
// Assumes srs_consts.svh holds the numbers.
package srs_pkg;

	typedef enum logic [2:0] {
		SRS_SRC_ANALOG_PAIR,
		SRS_SRC_ANALOG_ONE_PRESET,
		SRS_SRC_ANALOG_TWO_PRESET,
		SRS_SRC_PRESETS,
		SRS_SRC_KEYPAD,
		SRS_SRC_PRECISION
	} srs_source_t;

	typedef enum logic [1:0] {
		SRS_RAMP_FAST,
		SRS_RAMP_STANDARD,
		SRS_RAMP_STANDARD_DECEL_BOOST
	} srs_ramp_t;

	typedef enum logic [2:0] {
		SRS_TERM_NONE,
		SRS_TERM_LOCAL_REMOTE,
		SRS_TERM_JOG_FWD,
		SRS_TERM_PRESET_BIT0,
		SRS_TERM_PRESET_BIT1
	} srs_term_fn_t;

endpackage

// ---- rtl/srs_speed_reference_selector.sv ----
// Speed reference selector: picks the active drive reference and watches decel.
// Assumes terminal and drive-state inputs are synchronous unless stated.
//
// Overview of operation
// - Source field: six codes, analog pair to precision, resets to zero.
// - Auto-setup on: terminal destinations written from source field.
// - Terminal destinations user writable only while auto-setup disabled.
// - Auto-setup terminal function changes take effect at drive reset, or on re-enable after all-zero destinations are written.
// - Analog-preset modes: selector 2..8 fixes that preset, terminals unused.
// - Presets-only mode: selector 1..8 fixes that preset, terminals unused.
// - Selector 9 scans analog 1 and presets 2..8 with programmable dwell.
// - Jog forward accepted only in ready, inhibit or trip state.
// - Eight preset values held, addressed by preset number.
// - Keypad mode: keypad drives sequencer, keypad value is reference.
// - Keypad mode: sequencing bits ignored, jog disabled.
// - Precision mode: reference from coarse and fine parts.
// - Ramp field: fast, standard, standard with boost; resets to standard.
// - Ramp mode affects deceleration only; acceleration at programmed rate.
// - Speed not falling for 10 s while decelerating forces o_reference zero; o_reference_fine keeps fine_r.
// - Watchdog acts only in deceleration state, not on zero reference.
// - Fast mode decelerates at programmed rate, current limits only.
// - Standard mode regulates link voltage, lowering current at threshold.
// - Boost mode is standard ramp plus 20 percent motor voltage.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "srs_consts.svh"

module srs_speed_reference_selector #(
	parameter int REF_W        = 16,
	parameter int DWELL_W      = 32,
	parameter int NUM_PRESETS  = 8,
	parameter longint STALL_CYCLES = `SRS_STALL_CYCLES,
	parameter int BOOST_PCT    = 20
) (
	// Clock, reset, enable
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_ce,
	// Register port
	input  wire logic [4:0]           i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [31:0]          o_rdata,
	// Terminal pins, asynchronous
	input  wire logic                 i_select_terminal_a,
	input  wire logic                 i_select_terminal_b,
	// Analog and keypad inputs
	input  wire logic [REF_W-1:0]     i_analog1,
	input  wire logic [REF_W-1:0]     i_analog2,
	input  wire logic                 i_keypad_run,
	input  wire logic                 i_keypad_stop,
	input  wire logic [4:0]           i_seq_bits,
	// Drive state from sequencer
	input  wire logic                 i_state_ready,
	input  wire logic                 i_state_inhibit,
	input  wire logic                 i_state_trip,
	input  wire logic                 i_state_decel,
	input  wire logic                 i_speed_fell,
	input  wire logic                 i_link_at_level,
	// Reference and ramp outputs
	output logic      [REF_W-1:0]     o_reference,
	output logic      [REF_W-1:0]     o_reference_fine,
	output logic                      o_jog_forward,
	output logic                      o_local_remote,
	output logic                      o_keypad_control,
	output logic                      o_keypad_run,
	output logic                      o_keypad_stop,
	output logic      [4:0]           o_seq_bits,
	output logic                      o_ramp_fast,
	output logic                      o_accel_programmed,
	output logic                      o_decel_current_reduce,
	output logic      [7:0]           o_voltage_boost_pct,
	output logic                      o_stall_zero
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [2:0]        source_r;
	logic [3:0]        preset_sel_r;
	logic              auto_dis_r;
	logic [1:0]        ramp_r;
	logic [DWELL_W-1:0] dwell_r;
	logic [REF_W-1:0]  keypad_r;
	logic [REF_W-1:0]  coarse_r;
	logic [REF_W-1:0]  fine_r;
	logic [REF_W-1:0]  preset_r [NUM_PRESETS];
	logic [2:0]        dest_a_r;
	logic [2:0]        dest_b_r;
	logic [2:0]        fn_a_r;
	logic [2:0]        fn_b_r;
	logic              auto_done_r;
	logic [2:0]        sync_a_r;
	logic [2:0]        sync_b_r;
	logic              term_a_r;
	logic              term_b_r;
	logic [DWELL_W-1:0] dwell_cnt_r;
	logic [2:0]        scan_idx_r;
	logic [31:0]       stall_cnt_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire wr_src    = i_wr && (i_addr == `SRS_REG_SOURCE);
	wire wr_psel   = i_wr && (i_addr == `SRS_REG_PRESET_SEL);
	wire wr_adis   = i_wr && (i_addr == `SRS_REG_AUTO_DIS);
	wire wr_ramp   = i_wr && (i_addr == `SRS_REG_RAMP_MODE);
	wire wr_dwell  = i_wr && (i_addr == `SRS_REG_DWELL);
	wire wr_key    = i_wr && (i_addr == `SRS_REG_KEYPAD);
	wire wr_coarse = i_wr && (i_addr == `SRS_REG_PREC_COARSE);
	wire wr_fine   = i_wr && (i_addr == `SRS_REG_PREC_FINE);
	wire wr_dest   = i_wr && (i_addr == `SRS_REG_TERM_DEST) && auto_dis_r;
	wire wr_preset = i_wr && (i_addr[4:3] == 2'h2);
	// Illegal codes are dropped so the field only ever holds a defined mode
	wire src_ok    = i_wdata[2:0] <= 3'h5;
	wire psel_ok   = i_wdata[3:0] <= `SRS_PRESET_SCAN;
	wire ramp_ok   = i_wdata[1:0] <= 2'h2;

	// ----------------------------------------
	// Selection
	// ----------------------------------------
	wire is_pair   = source_r == srs_pkg::SRS_SRC_ANALOG_PAIR;
	wire is_a1p    = source_r == srs_pkg::SRS_SRC_ANALOG_ONE_PRESET;
	wire is_a2p    = source_r == srs_pkg::SRS_SRC_ANALOG_TWO_PRESET;
	wire is_pr     = source_r == srs_pkg::SRS_SRC_PRESETS;
	wire is_key    = source_r == srs_pkg::SRS_SRC_KEYPAD;
	wire is_prec   = source_r == srs_pkg::SRS_SRC_PRECISION;
	wire scan_on   = preset_sel_r == `SRS_PRESET_SCAN;
	wire fixed_sel = (preset_sel_r >= 4'h2 && preset_sel_r <= 4'h8)
		|| (is_pr && preset_sel_r == 4'h1);
	wire bit0_ok   = fn_a_r == srs_pkg::SRS_TERM_PRESET_BIT0;
	wire bit1_ok   = fn_b_r == srs_pkg::SRS_TERM_PRESET_BIT1;
	wire lr_ok     = fn_a_r == srs_pkg::SRS_TERM_LOCAL_REMOTE;
	wire jog_ok    = fn_b_r == srs_pkg::SRS_TERM_JOG_FWD;
	// Terminal preset bits only in selector 0 of the preset modes
	wire [1:0] term_bits = {term_b_r && bit1_ok, term_a_r && bit0_ok};
	wire [2:0] term_num  = (!is_pair && preset_sel_r == 4'h0) ?
		{1'b0, term_bits} : 3'h0;
	// Preset number in use, zero-based: 0 means analog or preset 1
	wire [2:0] sel_num = scan_on ? scan_idx_r :
		fixed_sel ? 3'(preset_sel_r - 4'h1) : term_num;
	wire analog_sel = (sel_num == 3'h0) && !is_pr;
	wire use_a2     = is_a2p || (is_pair && term_a_r && lr_ok);
	wire [REF_W-1:0] analog_val = use_a2 ? i_analog2 : i_analog1;
	wire [REF_W-1:0] sel_val =
		is_key ? keypad_r :
		is_prec ? coarse_r :
		analog_sel ? analog_val : preset_r[sel_num];
	wire allow_jog = i_state_ready || i_state_inhibit || i_state_trip;
	wire [3:0] stat_pre = (is_key || is_prec) ? 4'h0 : {1'b0, sel_num} + 4'h1;
	wire [2:0] stat_src = (is_key || is_prec) ? source_r :
		(is_pair && !fixed_sel && !(scan_on && sel_num != 3'h0)) ?
		(use_a2 ? 3'h2 : 3'h1) : (is_pair ? 3'h1 : source_r + 3'h0);

	// Terminal functions the source field asks for under auto-setup
	logic [2:0] auto_a;
	logic [2:0] auto_b;
	always_comb begin
		auto_a = srs_pkg::SRS_TERM_NONE;
		auto_b = srs_pkg::SRS_TERM_NONE;
		unique case (srs_pkg::srs_source_t'(source_r))
			srs_pkg::SRS_SRC_ANALOG_PAIR: begin
				auto_a = srs_pkg::SRS_TERM_LOCAL_REMOTE;
				auto_b = srs_pkg::SRS_TERM_JOG_FWD;
			end
			srs_pkg::SRS_SRC_ANALOG_ONE_PRESET,
			srs_pkg::SRS_SRC_ANALOG_TWO_PRESET,
			srs_pkg::SRS_SRC_PRESETS: begin
				auto_a = srs_pkg::SRS_TERM_PRESET_BIT0;
				auto_b = srs_pkg::SRS_TERM_PRESET_BIT1;
			end
			default: begin
				auto_a = srs_pkg::SRS_TERM_NONE;
				auto_b = srs_pkg::SRS_TERM_NONE;
			end
		endcase
	end
	// Fixed and scan selections leave both terminals without preset role
	// Analog pair mode keeps jog in every selector setting, local/remote only while analog is selected
	wire term_free = !is_pair && (fixed_sel || scan_on);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [31:0] rd_nxt;
	always_comb begin
		rd_nxt = 32'h0;
		if (i_addr[4:3] == 2'h2) begin
			rd_nxt = 32'(preset_r[i_addr[2:0]]);
		end else begin
			unique case (i_addr)
				`SRS_REG_SOURCE:      rd_nxt = {29'h0, source_r};
				`SRS_REG_PRESET_SEL:  rd_nxt = {28'h0, preset_sel_r};
				`SRS_REG_AUTO_DIS:    rd_nxt = {31'h0, auto_dis_r};
				`SRS_REG_RAMP_MODE:   rd_nxt = {30'h0, ramp_r};
				`SRS_REG_DWELL:       rd_nxt = 32'(dwell_r);
				`SRS_REG_KEYPAD:      rd_nxt = 32'(keypad_r);
				`SRS_REG_PREC_COARSE: rd_nxt = 32'(coarse_r);
				`SRS_REG_PREC_FINE:   rd_nxt = 32'(fine_r);
				`SRS_REG_STATUS:      rd_nxt = {24'h0, 1'b0, stat_src, stat_pre};
				`SRS_REG_TERM_DEST:   rd_nxt = {26'h0, dest_b_r, dest_a_r};
				default:              rd_nxt = 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			source_r     <= `SRS_RST_SOURCE;
			preset_sel_r <= `SRS_RST_PRESET_SEL;
			auto_dis_r   <= `SRS_RST_AUTO_DIS;
			ramp_r       <= `SRS_RST_RAMP_MODE;
			dwell_r      <= DWELL_W'(1);
			keypad_r     <= '0;
			coarse_r     <= '0;
			fine_r       <= '0;
			o_rdata      <= 32'h0;
		end else if (i_ce) begin
			if (wr_src && src_ok)
				source_r <= i_wdata[2:0];
			if (wr_psel && psel_ok)
				preset_sel_r <= i_wdata[3:0];
			if (wr_adis)
				auto_dis_r <= i_wdata[0];
			if (wr_ramp && ramp_ok)
				ramp_r <= i_wdata[1:0];
			if (wr_dwell)
				dwell_r <= i_wdata[DWELL_W-1:0];
			if (wr_key)
				keypad_r <= i_wdata[REF_W-1:0];
			if (wr_coarse)
				coarse_r <= i_wdata[REF_W-1:0];
			if (wr_fine)
				fine_r <= i_wdata[REF_W-1:0];
			o_rdata <= i_rd ? rd_nxt : 32'h0;
		end
	end

	generate
		for (genvar g = 0; g < NUM_PRESETS; g++) begin : g_preset
			always_ff @(posedge i_clk) begin
				if (!i_resetn)
					preset_r[g] <= '0;
				else if (i_ce && wr_preset && i_addr[2:0] == 3'(g))
					preset_r[g] <= i_wdata[REF_W-1:0];
			end
		end
	endgenerate

	// ----------------------------------------
	// Terminal configuration
	// ----------------------------------------
	// Auto-setup lands after reset, or on re-enable after an all-zero destination write, so a source change mid-run otherwise keeps old roles
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			dest_a_r <= 3'h0;
			dest_b_r <= 3'h0;
			fn_a_r   <= 3'h0;
			fn_b_r   <= 3'h0;
			auto_done_r <= 1'b0;
		end else if (i_ce) begin
			// Load once per reset or all-zero destination write, even when the roles it loads are both none
			if (!auto_done_r && !auto_dis_r) begin
				dest_a_r <= auto_a;
				dest_b_r <= auto_b;
				fn_a_r   <= auto_a;
				fn_b_r   <= auto_b;
				auto_done_r <= 1'b1;
			end else if (wr_dest) begin
				dest_a_r <= i_wdata[2:0];
				dest_b_r <= i_wdata[5:3];
				fn_a_r   <= i_wdata[2:0];
				fn_b_r   <= i_wdata[5:3];
				auto_done_r <= i_wdata[5:0] != 6'h0;
			end
		end
	end

	// ----------------------------------------
	// Terminal synchronisers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			sync_a_r <= 3'h0;
			sync_b_r <= 3'h0;
			term_a_r <= 1'b0;
			term_b_r <= 1'b0;
		end else if (i_ce) begin
			sync_a_r <= {sync_a_r[1:0], i_select_terminal_a};
			sync_b_r <= {sync_b_r[1:0], i_select_terminal_b};
			if (sync_a_r[2] == sync_a_r[1])
				term_a_r <= sync_a_r[2] && !term_free;
			if (sync_b_r[2] == sync_b_r[1])
				term_b_r <= sync_b_r[2] && !term_free;
		end
	end

	// ----------------------------------------
	// Scan timer
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			dwell_cnt_r <= '0;
			scan_idx_r  <= 3'h0;
		end else if (i_ce) begin
			if (!scan_on) begin
				dwell_cnt_r <= '0;
				scan_idx_r  <= 3'h0;
			end else if (dwell_cnt_r + DWELL_W'(1) >= dwell_r) begin
				dwell_cnt_r <= '0;
				scan_idx_r  <= scan_idx_r + 3'h1;
			end else begin
				dwell_cnt_r <= dwell_cnt_r + DWELL_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Stalled deceleration watchdog
	// ----------------------------------------
	// Counter saturates so the forced zero holds until decel ends or speed falls
	wire stall_hit = stall_cnt_r >= 32'(STALL_CYCLES - 1);
	// A falling speed ends the stall at once, not one cycle later
	wire stall_force = i_state_decel && !i_speed_fell && stall_hit;
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			stall_cnt_r <= 32'h0;
		else if (i_ce) begin
			if (!i_state_decel || i_speed_fell)
				stall_cnt_r <= 32'h0;
			else if (!stall_hit)
				stall_cnt_r <= stall_cnt_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire std_mode = ramp_r != srs_pkg::SRS_RAMP_FAST;
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_reference            <= '0;
			o_reference_fine       <= '0;
			o_jog_forward          <= 1'b0;
			o_local_remote         <= 1'b0;
			o_keypad_control       <= 1'b0;
			o_keypad_run           <= 1'b0;
			o_keypad_stop          <= 1'b0;
			o_seq_bits             <= 5'h0;
			o_ramp_fast            <= 1'b0;
			o_accel_programmed     <= 1'b1;
			o_decel_current_reduce <= 1'b0;
			o_voltage_boost_pct    <= 8'h0;
			o_stall_zero           <= 1'b0;
		end else if (i_ce) begin
			o_reference      <= stall_force ? '0 : sel_val;
			o_reference_fine <= is_prec ? fine_r : '0;
			o_jog_forward    <= is_pair && jog_ok && term_b_r && allow_jog
				&& !is_key;
			o_local_remote   <= is_pair && analog_sel && lr_ok && term_a_r;
			o_keypad_control <= is_key;
			o_keypad_run     <= is_key && i_keypad_run;
			o_keypad_stop    <= is_key && i_keypad_stop;
			o_seq_bits       <= is_key ? 5'h0 : i_seq_bits;
			o_ramp_fast      <= ramp_r == srs_pkg::SRS_RAMP_FAST;
			o_accel_programmed <= 1'b1;
			o_decel_current_reduce <= std_mode && i_state_decel
				&& i_link_at_level;
			o_voltage_boost_pct <= (i_state_decel
				&& ramp_r == srs_pkg::SRS_RAMP_STANDARD_DECEL_BOOST) ?
				8'(BOOST_PCT) : 8'h0;
			o_stall_zero     <= stall_force;
		end
	end

endmodule

// ---- sim/srs_sel_chk.sv ----
// Checker for the speed reference selector, bound to its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module srs_sel_chk #(
	parameter int REF_W        = 16,
	parameter longint STALL_CYCLES = 20,
	parameter int BOOST_PCT    = 20
) (
	input wire logic             i_clk,
	input wire logic             i_resetn,
	input wire logic             i_state_ready,
	input wire logic             i_state_inhibit,
	input wire logic             i_state_trip,
	input wire logic             i_state_decel,
	input wire logic             i_speed_fell,
	input wire logic             i_link_at_level,
	input wire logic [REF_W-1:0] o_reference,
	input wire logic             o_jog_forward,
	input wire logic             o_keypad_control,
	input wire logic [4:0]       o_seq_bits,
	input wire logic             o_ramp_fast,
	input wire logic             o_accel_programmed,
	input wire logic             o_decel_current_reduce,
	input wire logic [7:0]       o_voltage_boost_pct,
	input wire logic             o_stall_zero
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ----------------------------------------
	// Stalled-deceleration run length
	// ----------------------------------------
	int cnt;
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !i_state_decel || i_speed_fell)
			cnt <= 0;
		else if (cnt < 1000)
			cnt <= cnt + 1;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	accel_always_a: assert property (o_accel_programmed)
		else $error("accel flag low");
	jog_state_a: assert property (
		o_jog_forward |-> $past(i_state_ready || i_state_inhibit || i_state_trip))
		else $error("jog outside ready states");
	keypad_mask_a: assert property (
		o_keypad_control |-> !o_jog_forward && o_seq_bits == 5'h0)
		else $error("keypad mode leaks control");
	stall_ref_a: assert property (o_stall_zero |-> o_reference == '0)
		else $error("stall without zero reference");
	stall_late_a: assert property (cnt == STALL_CYCLES + 2 |-> o_stall_zero)
		else $error("stall not forced");
	stall_early_a: assert property ($rose(o_stall_zero) |-> cnt >= STALL_CYCLES - 1)
		else $error("stall forced early");
	stall_cause_a: assert property (
		o_stall_zero |-> $past(i_state_decel && !i_speed_fell))
		else $error("stall outside stalled decel");
	boost_value_a: assert property (
		o_voltage_boost_pct != 8'h0 |-> o_voltage_boost_pct == BOOST_PCT && $past(i_state_decel))
		else $error("boost wrong");
	fast_plain_a: assert property (
		o_ramp_fast |-> o_voltage_boost_pct == 8'h0 && !o_decel_current_reduce)
		else $error("fast ramp regulated");
	link_reduce_a: assert property (
		o_decel_current_reduce |-> $past(i_state_decel && i_link_at_level))
		else $error("current reduced without cause");
endmodule
bind srs_speed_reference_selector srs_sel_chk #(.REF_W(REF_W), .STALL_CYCLES(STALL_CYCLES),
	.BOOST_PCT(BOOST_PCT)) i_srs_sel_chk (.i_clk, .i_resetn, .i_state_ready,
	.i_state_inhibit, .i_state_trip, .i_state_decel, .i_speed_fell, .i_link_at_level,
	.o_reference, .o_jog_forward, .o_keypad_control, .o_seq_bits, .o_ramp_fast,
	.o_accel_programmed, .o_decel_current_reduce, .o_voltage_boost_pct, .o_stall_zero);

// ---- sim/srs_drive_model.sv ----
// Model of the sequencer and terminal wiring beside the selector.
// Assumes the bench picks a drive mode: 0 ready, 1 run, 2 stuck decel, 3 falling decel.
`timescale 1ns/1ps
module srs_drive_model (
	// Command from bench
	input  wire logic       i_clk,
	input  wire logic [1:0] i_mode,
	input  wire logic       i_term_a,
	input  wire logic       i_term_b,
	// Drive side signals
	output logic            o_state_ready,
	output logic            o_state_inhibit,
	output logic            o_state_trip,
	output logic            o_state_decel,
	output logic            o_speed_fell,
	output logic            o_link_at_level,
	output logic            o_term_a,
	output logic            o_term_b
);
	logic [1:0] ph_r = 2'h0;
	// Speed falls one cycle in four, so a falling decel never stalls
	// Mode 0 rotates through ready, inhibit and trip, all of which allow jog
	always @(posedge i_clk) begin
		ph_r <= ph_r + 2'h1;
		o_state_ready <= i_mode == 2'h0 && !ph_r[0];
		o_state_inhibit <= i_mode == 2'h0 && ph_r == 2'h1;
		o_state_trip <= i_mode == 2'h0 && ph_r == 2'h3;
		o_state_decel <= i_mode[1];
		o_speed_fell <= i_mode == 2'h3 && ph_r == 2'h0;
		o_link_at_level <= i_mode[1] && ph_r[1];
		o_term_a <= i_term_a;
		o_term_b <= i_term_b;
	end
endmodule

// ---- sim/tb_speed_reference_selector.sv ----
// Self-checking bench for the speed reference selector.
// Assumes the drive model on the terminal and sequencer side.
`timescale 1ns/1ps
module tb_speed_reference_selector;
	localparam int STALL = 20;
	logic        i_clk = 1'b0, i_resetn = 1'b0, wr = 1'b0, rd = 1'b0, ta = 1'b0, tb = 1'b0;
	logic        kr = 1'b0, ks = 1'b0, ce = 1'b1, rdy, inh, trp, dec, fell, lnk, pa, pb;
	logic [1:0]  mode = 2'h0;
	logic [4:0]  addr = 5'h0, seq = 5'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [15:0] an1 = 16'h0, an2 = 16'h0, ref_o, fine_o, p [1:8];
	logic [7:0]  boost;
	logic        jog, lr, kc, krun, kstop, fast, acc, cur, stall;
	logic [4:0]  seq_o;
	int          n_mismatch = 0, checks = 0, cyc = 0, seed = 6329, k;
	always #2 i_clk = ~i_clk;
	srs_drive_model i_srs_drive_model (.i_clk(i_clk), .i_mode(mode), .i_term_a(ta),
		.i_term_b(tb), .o_state_ready(rdy), .o_state_inhibit(inh), .o_state_trip(trp),
		.o_state_decel(dec), .o_speed_fell(fell), .o_link_at_level(lnk), .o_term_a(pa),
		.o_term_b(pb));
	srs_speed_reference_selector #(.STALL_CYCLES(STALL)) i_srs_speed_reference_selector (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_select_terminal_a(pa),
		.i_select_terminal_b(pb), .i_analog1(an1), .i_analog2(an2), .i_keypad_run(kr),
		.i_keypad_stop(ks), .i_seq_bits(seq), .i_state_ready(rdy), .i_state_inhibit(inh),
		.i_state_trip(trp), .i_state_decel(dec), .i_speed_fell(fell), .i_link_at_level(lnk),
		.o_reference(ref_o), .o_reference_fine(fine_o), .o_jog_forward(jog),
		.o_local_remote(lr), .o_keypad_control(kc), .o_keypad_run(krun),
		.o_keypad_stop(kstop), .o_seq_bits(seq_o), .o_ramp_fast(fast),
		.o_accel_programmed(acc), .o_decel_current_reduce(cur),
		.o_voltage_boost_pct(boost), .o_stall_zero(stall));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
		@(posedge i_clk) wr <= 1'b0;
	endtask
	task automatic rreg(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_clk) begin rd <= 1'b1; addr <= a; end
		@(posedge i_clk) rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		// Whole run needs a few hundred cycles
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		for (k = 0; k < 4; k++) begin rreg(k[4:0], v); chk(v, k == 3); end
		rreg(5'h1f, v); chk(v, 32'h0);
		rreg(5'h09, v); chk(v, 32'h11);
		wreg(5'h09, 32'h0); rreg(5'h09, v); chk(v, 32'h11);
		wreg(5'h00, 32'h6); rreg(5'h00, v); chk(v, 32'h0);
		$display("test registers done");
		@(posedge i_clk) begin tb <= 1'b1; an1 <= $random(seed); an2 <= $random(seed); end
		settle(8); chk(jog, 1'b1);
		@(posedge i_clk) begin mode <= 2'h1; ta <= 1'b1; end
		settle(8); chk(jog, 1'b0); chk(ref_o, an2); chk(lr, 1'b1);
		@(posedge i_clk) ta <= 1'b0;
		settle(8); chk(ref_o, an1);
		wreg(5'h00, 32'h1); rreg(5'h09, v); chk(v, 32'h11);
		$display("test terminals done");
		for (k = 1; k <= 8; k++) begin
			p[k] = {k[3:0], 12'($random(seed))};
			wreg(5'h0f + k[4:0], {16'h0, p[k]});
		end
		wreg(5'h01, 32'h1); settle(8); chk(ref_o, an1);
		for (k = 2; k <= 8; k++) begin wreg(5'h01, k); settle(4); chk(ref_o, p[k]); end
		wreg(5'h00, 32'h3);
		for (k = 1; k <= 8; k++) begin
			wreg(5'h01, k); settle(4); chk(ref_o, p[k]);
			rreg(5'h08, v); chk(v, 32'h30 + k);
		end
		wreg(5'h01, 32'ha); rreg(5'h01, v); chk(v, 32'h8);
		$display("test presets done");
		wreg(5'h02, 32'h1); wreg(5'h09, 32'h23); rreg(5'h09, v); chk(v, 32'h23);
		wreg(5'h01, 32'h0);
		for (k = 0; k < 4; k++) begin
			@(posedge i_clk) begin ta <= k[0]; tb <= k[1]; end
			settle(8); chk(ref_o, p[k+1]);
		end
		$display("test preset bits done");
		wreg(5'h04, 32'h5); wreg(5'h01, 32'h9);
		for (k = 2; k <= 8; k++) begin
			for (int n = 0; n < 200 && ref_o !== p[k]; n++) settle(1);
			chk(ref_o, p[k]);
		end
		$display("test scan done");
		v = $random(seed);
		wreg(5'h00, 32'h4); wreg(5'h05, {16'h0, v[15:0]});
		@(posedge i_clk) begin seq <= $random(seed); kr <= 1'b1; ks <= 1'b1; end
		settle(8); chk(ref_o, v[15:0]); chk(kc, 1'b1);
		chk({krun, kstop}, 2'h3); chk(seq_o, 5'h0); chk(jog, 1'b0);
		wreg(5'h00, 32'h5); wreg(5'h06, {16'h0, v[31:16]}); wreg(5'h07, {16'h0, p[3]});
		settle(4); chk(ref_o, v[31:16]); chk(fine_o, p[3]);
		$display("test keypad precision done");
		wreg(5'h03, 32'h3); rreg(5'h03, v); chk(v, 32'h1);
		wreg(5'h03, 32'h0); settle(4); chk(fast, 1'b1); chk(acc, 1'b1);
		wreg(5'h03, 32'h2);
		@(posedge i_clk) mode <= 2'h3;
		settle(8); chk(boost, 8'd20);
		wreg(5'h03, 32'h1); settle(40); chk(boost, 8'h0); chk(stall, 1'b0);
		for (int n = 0; n < 8 && cur !== 1'b1; n++) settle(1);
		chk(cur, 1'b1);
		$display("test ramp done");
		wreg(5'h00, 32'h3); wreg(5'h01, 32'h1);
		@(posedge i_clk) mode <= 2'h2;
		settle(STALL + 10); chk(stall, 1'b1); chk(ref_o, 16'h0);
		@(posedge i_clk) mode <= 2'h1;
		settle(8); chk(stall, 1'b0); chk(ref_o, p[1]);
		$display("test stall done");
		@(posedge i_clk) ce <= 1'b0;
		wreg(5'h00, 32'h4);
		@(posedge i_clk) ce <= 1'b1;
		rreg(5'h00, v); chk(v, 32'h3);
		$display("test clock enable done");
		close_out();
	end
endmodule
